// File: cell_monitor_cfg.svh
`ifndef CELL_MONITOR_CFG_SVH
`define CELL_MONITOR_CFG_SVH

`define CM_TARGET_ADDR 7'h5c
`define CM_REG_SLEEP_MON 8'h00
`define CM_REG_BALANCE 8'h01
`define CM_RESET_BYTE 8'h00
`define CM_UNMAPPED_READ 8'h00

`define CM_BIT_SLEEP 7
`define CM_BIT_WAKE 6
`define CM_BIT_MON_EN 5
`define CM_RSVD_HI 4
`define CM_RSVD_LO 3
`define CM_SEL_HI 2
`define CM_SEL_LO 0
`define CM_BAL_HI 6
`define CM_TAP_RESERVED 3'h7
`define CM_TAPS_OFF 7'h7f
`define CM_TAP_ONE 7'h01

`define CM_BITS_PER_BYTE 4'h8
`define CM_BIT_FIRST 4'h1
`define CM_BIT_NONE 4'h0

`define CM_CLK_PERIOD_NS 10
`define CM_WAKE_QUAL_NS 10000
`define CM_WAKE_QUAL_CYC ((`CM_WAKE_QUAL_NS + `CM_CLK_PERIOD_NS - 1) / `CM_CLK_PERIOD_NS)
`define CM_WAKE_CNT_W 10

`endif

// File: cell_monitor_pkg.sv
package cell_monitor_pkg;

    typedef enum logic [3:0] {
        PH_IDLE = 4'h0,
        PH_ADDR = 4'h1,
        PH_ADDR_ACK = 4'h3,
        PH_REG = 4'h2,
        PH_REG_ACK = 4'h6,
        PH_WDATA = 4'h7,
        PH_WDATA_ACK = 4'h5,
        PH_RDATA = 4'h4,
        PH_RDATA_ACK = 4'hc
    } bus_phase_e;

    typedef struct packed {
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic [1:0] wakeHighSync;
        logic [1:0] wakeLowSync;
        logic [1:0] gateCtlSync;
        logic sclPrev;
        logic sdaPrev;
        bus_phase_e phase;
        logic [3:0] bitCount;
        logic [7:0] shift;
        logic readMode;
        logic [7:0] pointer;
        logic sdaOut;
        logic sdaOe;
        logic sleepRequest;
        logic hostWake;
        logic detectedWake;
        logic monitorEnable;
        logic [1:0] reservedBits;
        logic [2:0] cellTapSelect;
        logic [7:0] balance;
        logic [9:0] wakeCount;
        logic [6:0] tapSwitchControlsN;
        logic dischargeGateOutput;
    } ctl_state_s;

endpackage

// File: cell_monitor_control_regs.sv
// Function
// - Bit 7 requests sleep procedure
// - Wake flag forces sleep zero, drops sleep commands
// - Qualified wake pin sets flag, clears sleep
// - Wake pin below low level clears flag
// - Host-written wake flag is held
// - Wake flag reads detected pin status only
// - Bit 5 enables the voltage monitor
// - Bits 2..0 select tap one to seven
// - Tap switches active low, one-hot when enabled, all off for select seven
// - Register one bits 6..0 enable balancing
// - Any balance combination allowed
// - Balance holds until cleared or sleep
// - Gate high only when awake and enabled
// - Acknowledge only the fixed target address
// - Register zero at address zero, resets zero
`timescale 1ns/10ps
`include "cell_monitor_cfg.svh"

module cell_monitor_control_regs
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic wakeAboveThreshold,
    input wire logic wakeBelowLowLevel,
    input wire logic dischargeGateControlInput,
    output logic sleepRequest,
    output logic monitorEnable,
    output logic [6:0] tapSwitchControlsN,
    output logic [6:0] balanceEnables,
    output logic dischargeGateOutput
);

    cell_monitor_pkg::ctl_state_s state_reg;
    cell_monitor_pkg::ctl_state_s state_next;

    logic sclNow;
    logic sdaNow;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic [7:0] readByte;
    logic wakeFlagNext;
    logic sleepCmd;

    assign sclNow = state_reg.sclSync[1];
    assign sdaNow = state_reg.sdaSync[1];
    assign sclRise = sclNow && !state_reg.sclPrev;
    assign sclFall = !sclNow && state_reg.sclPrev;
    assign startSeen = sclNow && state_reg.sclPrev && state_reg.sdaPrev && !sdaNow;
    assign stopSeen = sclNow && state_reg.sclPrev && !state_reg.sdaPrev && sdaNow;

    // Wake bit returns the pin status, never the host-written copy
    always_comb
    begin
        if (state_reg.pointer == `CM_REG_SLEEP_MON)
        begin
            readByte = {state_reg.sleepRequest, state_reg.detectedWake,
                        state_reg.monitorEnable, state_reg.reservedBits,
                        state_reg.cellTapSelect};
        end
        else if (state_reg.pointer == `CM_REG_BALANCE)
        begin
            readByte = state_reg.balance;
        end
        else
        begin
            readByte = `CM_UNMAPPED_READ;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        sleepCmd = 1'b0;

        state_next.sclSync = {state_reg.sclSync[0], sclIn};
        state_next.sdaSync = {state_reg.sdaSync[0], sdaIn};
        state_next.wakeHighSync = {state_reg.wakeHighSync[0], wakeAboveThreshold};
        state_next.wakeLowSync = {state_reg.wakeLowSync[0], wakeBelowLowLevel};
        state_next.gateCtlSync = {state_reg.gateCtlSync[0], dischargeGateControlInput};
        state_next.sclPrev = sclNow;
        state_next.sdaPrev = sdaNow;
        state_next.sdaOut = 1'b0;

        if (startSeen)
        begin
            state_next.phase = cell_monitor_pkg::PH_ADDR;
            state_next.bitCount = `CM_BIT_NONE;
            state_next.sdaOe = 1'b0;
        end
        else if (stopSeen)
        begin
            state_next.phase = cell_monitor_pkg::PH_IDLE;
            state_next.sdaOe = 1'b0;
        end
        else
        begin
            unique case (state_reg.phase)
                cell_monitor_pkg::PH_IDLE:
                begin
                    state_next.sdaOe = 1'b0;
                end
                cell_monitor_pkg::PH_ADDR,
                cell_monitor_pkg::PH_REG,
                cell_monitor_pkg::PH_WDATA:
                begin
                    if (sclRise)
                    begin
                        state_next.shift = {state_reg.shift[6:0], sdaNow};
                        state_next.bitCount = state_reg.bitCount + `CM_BIT_FIRST;
                    end
                    else if (sclFall && state_reg.bitCount == `CM_BITS_PER_BYTE)
                    begin
                        state_next.sdaOe = 1'b1;
                        if (state_reg.phase == cell_monitor_pkg::PH_ADDR)
                        begin
                            if (state_reg.shift[7:1] == `CM_TARGET_ADDR)
                            begin
                                state_next.readMode = state_reg.shift[0];
                                state_next.phase = cell_monitor_pkg::PH_ADDR_ACK;
                            end
                            else
                            begin
                                state_next.sdaOe = 1'b0;
                                state_next.phase = cell_monitor_pkg::PH_IDLE;
                            end
                        end
                        else if (state_reg.phase == cell_monitor_pkg::PH_REG)
                        begin
                            state_next.pointer = state_reg.shift;
                            state_next.phase = cell_monitor_pkg::PH_REG_ACK;
                        end
                        else
                        begin
                            state_next.phase = cell_monitor_pkg::PH_WDATA_ACK;
                            if (state_reg.pointer == `CM_REG_SLEEP_MON)
                            begin
                                state_next.sleepRequest = state_reg.shift[`CM_BIT_SLEEP];
                                state_next.hostWake = state_reg.shift[`CM_BIT_WAKE];
                                state_next.monitorEnable = state_reg.shift[`CM_BIT_MON_EN];
                                state_next.reservedBits =
                                    state_reg.shift[`CM_RSVD_HI:`CM_RSVD_LO];
                                state_next.cellTapSelect =
                                    state_reg.shift[`CM_SEL_HI:`CM_SEL_LO];
                                sleepCmd = state_reg.shift[`CM_BIT_SLEEP];
                            end
                            else if (state_reg.pointer == `CM_REG_BALANCE)
                            begin
                                // Stored as written, no one-hot check
                                state_next.balance = state_reg.shift;
                            end
                        end
                    end
                end
                cell_monitor_pkg::PH_ADDR_ACK:
                begin
                    if (sclFall)
                    begin
                        if (state_reg.readMode)
                        begin
                            state_next.shift = readByte;
                            state_next.sdaOe = !readByte[7];
                            state_next.bitCount = `CM_BIT_FIRST;
                            state_next.phase = cell_monitor_pkg::PH_RDATA;
                        end
                        else
                        begin
                            state_next.sdaOe = 1'b0;
                            state_next.bitCount = `CM_BIT_NONE;
                            state_next.phase = cell_monitor_pkg::PH_REG;
                        end
                    end
                end
                cell_monitor_pkg::PH_REG_ACK,
                cell_monitor_pkg::PH_WDATA_ACK:
                begin
                    // Later bytes rewrite the same register
                    if (sclFall)
                    begin
                        state_next.sdaOe = 1'b0;
                        state_next.bitCount = `CM_BIT_NONE;
                        state_next.phase = cell_monitor_pkg::PH_WDATA;
                    end
                end
                cell_monitor_pkg::PH_RDATA:
                begin
                    if (sclFall)
                    begin
                        if (state_reg.bitCount == `CM_BITS_PER_BYTE)
                        begin
                            state_next.sdaOe = 1'b0;
                            state_next.phase = cell_monitor_pkg::PH_RDATA_ACK;
                        end
                        else
                        begin
                            state_next.shift = {state_reg.shift[6:0], 1'b0};
                            state_next.sdaOe = !state_reg.shift[6];
                            state_next.bitCount = state_reg.bitCount + `CM_BIT_FIRST;
                        end
                    end
                end
                cell_monitor_pkg::PH_RDATA_ACK:
                begin
                    if (sclRise && sdaNow)
                    begin
                        state_next.phase = cell_monitor_pkg::PH_IDLE;
                    end
                    else if (sclFall)
                    begin
                        state_next.shift = readByte;
                        state_next.sdaOe = !readByte[7];
                        state_next.bitCount = `CM_BIT_FIRST;
                        state_next.phase = cell_monitor_pkg::PH_RDATA;
                    end
                end
                default:
                begin
                    state_next.sdaOe = 1'b0;
                    state_next.phase = cell_monitor_pkg::PH_IDLE;
                end
            endcase
        end

        // Low level wins: a pin under the low threshold cannot also be qualifying
        if (state_reg.wakeLowSync[1])
        begin
            state_next.detectedWake = 1'b0;
            state_next.wakeCount = '0;
        end
        else if (state_reg.wakeHighSync[1])
        begin
            if (state_reg.wakeCount == `CM_WAKE_CNT_W'(`CM_WAKE_QUAL_CYC))
            begin
                state_next.detectedWake = 1'b1;
            end
            else
            begin
                state_next.wakeCount = state_reg.wakeCount + `CM_WAKE_CNT_W'(1);
            end
        end
        else
        begin
            state_next.wakeCount = '0;
        end

        wakeFlagNext = state_next.detectedWake || state_next.hostWake;
        if (wakeFlagNext)
        begin
            state_next.sleepRequest = 1'b0;
        end
        else if (sleepCmd)
        begin
            state_next.balance = `CM_RESET_BYTE;
        end

        if (!state_next.monitorEnable || state_next.cellTapSelect == `CM_TAP_RESERVED)
        begin
            state_next.tapSwitchControlsN = `CM_TAPS_OFF;
        end
        else
        begin
            state_next.tapSwitchControlsN =
                ~(`CM_TAP_ONE << state_next.cellTapSelect);
        end

        state_next.dischargeGateOutput =
            !state_next.sleepRequest && state_reg.gateCtlSync[1];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= '0;
            state_reg.sclSync <= 2'h3;
            state_reg.sdaSync <= 2'h3;
            state_reg.sclPrev <= 1'b1;
            state_reg.sdaPrev <= 1'b1;
            state_reg.phase <= cell_monitor_pkg::PH_IDLE;
            state_reg.tapSwitchControlsN <= `CM_TAPS_OFF;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sdaOut = state_reg.sdaOut;
    assign sdaOe = state_reg.sdaOe;
    assign sleepRequest = state_reg.sleepRequest;
    assign monitorEnable = state_reg.monitorEnable;
    assign tapSwitchControlsN = state_reg.tapSwitchControlsN;
    assign balanceEnables = state_reg.balance[`CM_BAL_HI:0];
    assign dischargeGateOutput = state_reg.dischargeGateOutput;

endmodule

// File: cell_monitor_control_regs_sva.sv
`timescale 1ns/10ps
module cell_monitor_control_regs_sva
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic wakeAboveThreshold,
    input wire logic wakeBelowLowLevel,
    input wire logic dischargeGateControlInput,
    input wire logic sleepRequest,
    input wire logic monitorEnable,
    input wire logic [6:0] tapSwitchControlsN,
    input wire logic [6:0] balanceEnables,
    input wire logic dischargeGateOutput
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic [10:0] qualCnt;
    // Saturates so a long wake never wraps to zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            qualCnt <= 11'h000;
        else if (!wakeAboveThreshold || wakeBelowLowLevel)
            qualCnt <= 11'h000;
        else if (qualCnt != 11'h7ff)
            qualCnt <= qualCnt + 11'h001;
    end
    sequence ackDrive;
        $rose(sdaOe);
    endsequence
    reset_outs_a: assert property ($rose(arst_n) |-> tapSwitchControlsN == 7'h7f
        && balanceEnables == 7'h00 && !sleepRequest) else $error("outputs not reset");
    taps_off_a: assert property (!monitorEnable |-> tapSwitchControlsN == 7'h7f)
        else $error("tap switch on while disabled");
    taps_onehot_a: assert property (monitorEnable |-> $onehot0(~tapSwitchControlsN))
        else $error("more than one tap switch on");
    gate_sleep_a: assert property (sleepRequest |-> !dischargeGateOutput)
        else $error("gate high during sleep");
    // Two sync flops plus the output register: three clocks of latency
    gate_input_a: assert property (dischargeGateOutput
        |-> $past(dischargeGateControlInput, 3)) else $error("gate high without control input");
    wake_sleep_a: assert property (qualCnt > 11'h3fc |-> !sleepRequest)
        else $error("sleep kept during qualified wake");
    bal_write_a: assert property (!$stable(balanceEnables) |-> ackDrive)
        else $error("balance changed outside a write");
    mon_write_a: assert property ($changed(monitorEnable) |-> ackDrive)
        else $error("monitor enable changed outside a write");
    sleep_write_a: assert property ($rose(sleepRequest) |-> ackDrive ##0 balanceEnables == 7'h00)
        else $error("sleep without write or balance kept");
    sda_low_a: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data line moved while clock high");
endmodule

bind cell_monitor_control_regs cell_monitor_control_regs_sva i_sva
(
    .clk(clk), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .wakeAboveThreshold(wakeAboveThreshold), .wakeBelowLowLevel(wakeBelowLowLevel),
    .dischargeGateControlInput(dischargeGateControlInput), .sleepRequest(sleepRequest),
    .monitorEnable(monitorEnable), .tapSwitchControlsN(tapSwitchControlsN),
    .balanceEnables(balanceEnables), .dischargeGateOutput(dischargeGateOutput)
);

// File: i2c_host_model.sv
`timescale 1ns/10ps
module i2c_host_model
(
    input wire logic clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sda
);
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Data moves two clocks after the fall so no false start is seen
    task automatic start;
        w(2);
        sda = 1'b1;
        w(8);
        scl = 1'b1;
        w(8);
        sda = 1'b0;
        w(8);
        scl = 1'b0;
    endtask
    task automatic stop;
        w(2);
        sda = 1'b0;
        w(8);
        scl = 1'b1;
        w(8);
        sda = 1'b1;
        w(8);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        for (int i = 8; i >= 0; i--)
        begin
            w(2);
            sda = (i == 0) ? 1'b1 : d[i - 1];
            w(8);
            scl = 1'b1;
            w(8);
            if (i == 0)
                ack = sdaLine;
            else
                q[i - 1] = sdaLine;
            scl = 1'b0;
        end
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic scl, hostSda, sdaOut, sdaOe, sleepRequest, monitorEnable, gateOut, a;
    logic wakeHi = 1'b0;
    logic wakeLo = 1'b0;
    logic gateCtl = 1'b0;
    logic [6:0] taps, bal;
    logic [7:0] q, r0, r1, e;
    logic hostWake, detWake;
    wire logic sdaLine = hostSda & ~sdaOe;
    int nFail = 0;
    int numChecks = 0;
    always #5 clk = ~clk;
    i2c_host_model i_host (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sda(hostSda));
    cell_monitor_control_regs i_dut (.clk(clk), .arst_n(arst_n), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .wakeAboveThreshold(wakeHi), .wakeBelowLowLevel(wakeLo),
        .dischargeGateControlInput(gateCtl), .sleepRequest(sleepRequest),
        .monitorEnable(monitorEnable), .tapSwitchControlsN(taps), .balanceEnables(bal),
        .dischargeGateOutput(gateOut));
    task chk(input string nm, input logic [7:0] x, input logic [7:0] g);
        numChecks++;
        if (g !== x)
        begin
            nFail++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask
    task tallyAndFinish;
        if (nFail == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] ra, input logic [7:0] d);
        i_host.start;
        i_host.xfer(8'hb8, q, a);
        chk("ack", 8'h00, {7'h00, a});
        i_host.xfer(ra, q, a);
        i_host.xfer(d, q, a);
        i_host.stop;
        if (ra == 8'h00)
        begin
            hostWake = d[6];
            r0 = {d[7] && !hostWake && !detWake, 1'b0, d[5:0]};
            if (r0[7])
                r1 = 8'h00;
        end
        if (ra == 8'h01)
            r1 = d;
    endtask
    task rd(input logic [7:0] ra, input logic [7:0] x);
        i_host.start;
        i_host.xfer(8'hb8, q, a);
        i_host.xfer(ra, q, a);
        i_host.start;
        i_host.xfer(8'hb9, q, a);
        i_host.xfer(8'hff, q, a);
        i_host.stop;
        chk("read", x, q);
    endtask
    task verify;
        e = (!r0[5] || r0[2:0] == 3'h7) ? 8'h7f : ~(8'h01 << r0[2:0]) & 8'h7f;
        chk("taps", e, {1'b0, taps});
        chk("bal", {1'b0, r1[6:0]}, {1'b0, bal});
        chk("sleep", {7'h00, r0[7]}, {7'h00, sleepRequest});
        chk("gate", {7'h00, gateCtl && !r0[7]}, {7'h00, gateOut});
        chk("monitor", {7'h00, r0[5]}, {7'h00, monitorEnable});
        chk("sdaOut", 8'h00, {7'h00, sdaOut});
        rd(8'h00, {r0[7], detWake, r0[5:0]});
        rd(8'h01, r1);
    endtask
    initial
    begin
        // Tests need about 35k clocks; twice that means a hang
        #700000;
        nFail++;
        tallyAndFinish;
    end
    initial
    begin
        {r0, r1, hostWake, detWake} = '0;
        void'($urandom(18566));
        repeat (2) @(posedge clk);
        #1 arst_n = 1'b1;
        i_host.w(3);
        verify;
        // Even cells only: no neighbours together, reserved bit clear
        wr(8'h01, 8'($urandom) & 8'h55);
        verify;
        // Balancing off before the monitor is used
        wr(8'h01, 8'h00);
        gateCtl = 1'b1;
        for (int s = 0; s < 7; s++)
        begin
            wr(8'h00, 8'h20 | 8'(s));
            verify;
        end
        wr(8'h00, 8'h07);
        verify;
        wr(8'h00, 8'h80);
        verify;
        wakeHi = 1'b1;
        i_host.w(1100);
        detWake = 1'b1;
        r0[7] = 1'b0;
        verify;
        wr(8'h00, 8'h80);
        verify;
        wakeHi = 1'b0;
        wakeLo = 1'b1;
        i_host.w(6);
        detWake = 1'b0;
        wakeLo = 1'b0;
        verify;
        wr(8'h00, 8'h40);
        verify;
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h55);
        wr(8'h00, 8'h80);
        verify;
        rd(8'h05, 8'h00);
        i_host.start;
        i_host.xfer(8'h70, q, a);
        i_host.stop;
        chk("nack", 8'h01, {7'h00, a});
        tallyAndFinish;
    end
endmodule
